// file: logic/gpio_port_pkg.sv
// Package: constants, register map and pin allocation tables of the general-purpose pin port
package gpio_port_pkg;

  // ********************************************
  // Sizes
  // ********************************************
  localparam int N_GIO = 18; // Bidirectional pins
  localparam int N_DO = 2; // Output-only pins
  localparam int N_PERIPH = 4; // Peripherals that can claim pins

  // ********************************************
  // Register byte offsets
  // ********************************************
  localparam logic [7:0] OFS_DIR = 8'h00; // Direction, 1 = output
  localparam logic [7:0] OFS_DOUT = 8'h04; // Output levels, [19:18] output-only pins
  localparam logic [7:0] OFS_PULL_EN = 8'h08; // Pull resistor connected
  localparam logic [7:0] OFS_PULL_UP = 8'h0C; // 1 = pull-up, 0 = pull-down
  localparam logic [7:0] OFS_LEVEL = 8'h10; // Pin levels, read only
  localparam logic [7:0] OFS_INT_EN = 8'h14; // Change interrupt enables
  localparam logic [7:0] OFS_INT_RISE = 8'h18; // 1 = rising edge, 0 = falling edge
  localparam logic [7:0] OFS_INT_STAT = 8'h1C; // Sticky status, write one to clear
  localparam logic [7:0] OFS_PERIPH = 8'h20; // Peripheral enables and alternates
  localparam logic [7:0] OFS_RELEASE = 8'h24; // Pins released by their peripheral
  localparam logic [7:0] OFS_RADIO = 8'h28; // Radio indicator control

  // ********************************************
  // Field positions
  // ********************************************
  localparam int PERIPH_EN_LSB = 0; // Enable bits [3:0]
  localparam int PERIPH_ALT_LSB = 8; // Alternate allocation bits [11:8]
  localparam int RADIO_EN_BIT = 0; // Radio indicators on
  localparam int RADIO_ALT_BIT = 1; // Use the second pin pair
  localparam int DO_LSB = 18; // Output-only pins inside the output register

  // ********************************************
  // Pin numbers for radio indicators
  // ********************************************
  localparam int TX_PIN_A = 1;
  localparam int TX_PIN_B = 3;
  localparam int RX_PIN_A = 0;
  localparam int RX_PIN_B = 2;

  // ********************************************
  // Reset values
  // ********************************************
  localparam logic [N_GIO-1:0] PULL_EN_RST = 18'h3_FFFF; // All pulls connected
  localparam logic [N_GIO-1:0] PULL_UP_RST = 18'h3_FFFF; // Default pull per pin

  // ********************************************
  // Pin allocations per peripheral: primary and alternate
  // ********************************************
  localparam logic [N_PERIPH-1:0][N_GIO-1:0] MAP_A = {
    18'h0_C000, 18'h0_0F00, 18'h0_00F0, 18'h0_000F
  };
  localparam logic [N_PERIPH-1:0][N_GIO-1:0] MAP_B = {
    18'h3_0000, 18'h0_F000, 18'h0_0F00, 18'h0_00F0
  };

endpackage

// file: logic/gpio_port.sv
// Module: general-purpose pin port with AHB-Lite registers, peripheral muxing and sleep hold
//
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Eighteen pins, direction and pull each
// - Two extra output-only pins
// - Enabled peripheral takes its allocated pins
// - Each peripheral has two pin allocations
// - Peripheral may release pins it needs not
// - Reset: peripherals off, pins inputs, pulled
// - Free pins: set direction, read or write
// - Pull per pin, kept through sleep
// - Input edge interrupt, edge select, enable
// - Enabled pin interrupts wake sleeping device
// - Interrupt status readable by software
// - Pin levels always readable
// - Sleep holds direction and output levels
// - After wake, held values under port registers
// - Peripherals stay off after wake
// - Radio transmit state on indicator pin
// - Radio receive state on second pin
module gpio_port
  import gpio_port_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Pins
  input wire logic [gpio_port_pkg::N_GIO-1:0] general_io_pin_in,
  output logic [gpio_port_pkg::N_GIO-1:0] general_io_pin_out,
  output logic [gpio_port_pkg::N_GIO-1:0] general_io_pin_oe_n,
  output logic [gpio_port_pkg::N_GIO-1:0] pullup_resistor_en,
  output logic [gpio_port_pkg::N_GIO-1:0] pulldown_resistor_en,
  output logic [gpio_port_pkg::N_DO-1:0] output_only_pin,
  // Peripherals
  input wire logic [gpio_port_pkg::N_PERIPH-1:0][gpio_port_pkg::N_GIO-1:0] periph_out,
  input wire logic [gpio_port_pkg::N_PERIPH-1:0][gpio_port_pkg::N_GIO-1:0] periph_drive,
  output logic [gpio_port_pkg::N_GIO-1:0] pin_level,
  // Radio state
  input wire logic radio_tx_state,
  input wire logic radio_rx_state,
  // Power control
  input wire logic sleep_req,
  output logic wake_event,
  output logic irq
);
  import gpio_port_pkg::*;

  // ********************************************
  // State
  // ********************************************
  typedef struct packed {
    logic [N_GIO-1:0] sync1; // First synchroniser stage
    logic [N_GIO-1:0] sync2; // Second synchroniser stage
    logic [N_GIO-1:0] prev; // Level one cycle earlier, for edges
    logic [N_GIO-1:0] dir; // Direction register
    logic [N_GIO+N_DO-1:0] dout; // Output register
    logic [N_GIO-1:0] pull_en; // Pull connected
    logic [N_GIO-1:0] pull_up; // Pull kind
    logic [N_GIO-1:0] int_en; // Interrupt enables
    logic [N_GIO-1:0] int_rise; // Edge select
    logic [N_GIO-1:0] int_stat; // Sticky status
    logic [N_PERIPH-1:0] per_en; // Peripheral enables
    logic [N_PERIPH-1:0] per_alt; // Alternate allocation
    logic [N_GIO-1:0] release_m; // Released pins
    logic radio_en; // Radio indicators on
    logic radio_alt; // Radio pin pair select
    logic sleep; // Sleep request seen last cycle
    logic [N_GIO-1:0] pin_out; // Registered pin drive
    logic [N_GIO-1:0] pin_oe_n; // Registered enable, low drives
    logic [N_GIO-1:0] pu; // Pull-up switch
    logic [N_GIO-1:0] pd; // Pull-down switch
    logic [N_DO-1:0] do_q; // Output-only pins
    logic wr_pend; // Write data phase pending
    logic [7:0] wr_addr; // Latched write offset
    logic [31:0] rdata; // Read data for the data phase
    logic irq; // Interrupt request
    logic wake; // Wake request
  } state_t;

  state_t s_q; // Registered state
  state_t s_d; // Next state

  // Pin ownership, worked out from the current state
  logic [N_GIO-1:0] claim; // Pins held by a peripheral
  logic [N_GIO-1:0] per_o; // Peripheral drive values
  logic [N_GIO-1:0] per_d; // Peripheral direction
  logic [N_GIO-1:0] radio_m; // Pins held by radio indicators
  logic [N_GIO-1:0] eff_dir; // Direction seen at the pins
  logic [N_GIO-1:0] eff_out; // Output level seen at the pins
  logic [N_GIO-1:0] set_vec; // Status bits set this cycle
  logic sleep_entry; // First cycle of sleep request

  // ********************************************
  // Pin ownership
  // ********************************************
  // Lowest numbered peripheral wins when allocations overlap; radio wins over all
  always_comb begin
    logic [N_GIO-1:0] m;
    m = '0;
    claim = '0;
    per_o = '0;
    per_d = '0;
    radio_m = '0;
    for (int p = N_PERIPH - 1; p >= 0; p--) begin
      if (s_q.per_en[p]) begin
        m = (s_q.per_alt[p] ? MAP_B[p] : MAP_A[p]) & ~s_q.release_m;
      end else begin
        m = '0;
      end
      claim = claim | m;
      per_o = (per_o & ~m) | (periph_out[p] & m);
      per_d = (per_d & ~m) | (periph_drive[p] & m);
    end
    eff_dir = (s_q.dir & ~claim) | (per_d & claim);
    eff_out = (s_q.dout[N_GIO-1:0] & ~claim) | (per_o & claim);
    if (s_q.radio_en) begin
      // Both indicators are outputs while the radio owns them
      radio_m[s_q.radio_alt ? TX_PIN_B : TX_PIN_A] = 1'b1;
      radio_m[s_q.radio_alt ? RX_PIN_B : RX_PIN_A] = 1'b1;
      eff_dir = eff_dir | radio_m;
      eff_out[s_q.radio_alt ? TX_PIN_B : TX_PIN_A] = radio_tx_state;
      eff_out[s_q.radio_alt ? RX_PIN_B : RX_PIN_A] = radio_rx_state;
    end
  end

  // Edges only count on pins that are inputs
  assign set_vec = ~eff_dir & ((s_q.sync2 & ~s_q.prev & s_q.int_rise)
                   | (~s_q.sync2 & s_q.prev & ~s_q.int_rise));
  assign sleep_entry = sleep_req & ~s_q.sleep;

  // ********************************************
  // Next state
  // ********************************************
  always_comb begin
    logic [N_GIO-1:0] clr;
    clr = '0;
    s_d = s_q;
    // Sync stage one feeds only stage two
    s_d.sync1 = general_io_pin_in;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    s_d.sleep = sleep_req;
    // Address phase: latch writes, fetch read data now for a zero-wait answer
    s_d.wr_pend = 1'b0;
    s_d.rdata = '0;
    if (hsel && hready && htrans[1]) begin
      s_d.wr_pend = hwrite;
      s_d.wr_addr = haddr[7:0];
      if (!hwrite) begin
        case (haddr[7:0])
          OFS_DIR: s_d.rdata = 32'(s_q.dir);
          OFS_DOUT: s_d.rdata = 32'(s_q.dout);
          OFS_PULL_EN: s_d.rdata = 32'(s_q.pull_en);
          OFS_PULL_UP: s_d.rdata = 32'(s_q.pull_up);
          OFS_LEVEL: s_d.rdata = 32'(s_q.sync2);
          OFS_INT_EN: s_d.rdata = 32'(s_q.int_en);
          OFS_INT_RISE: s_d.rdata = 32'(s_q.int_rise);
          OFS_INT_STAT: s_d.rdata = 32'(s_q.int_stat);
          OFS_PERIPH: begin
            s_d.rdata[PERIPH_EN_LSB +: N_PERIPH] = s_q.per_en;
            s_d.rdata[PERIPH_ALT_LSB +: N_PERIPH] = s_q.per_alt;
          end
          OFS_RELEASE: s_d.rdata = 32'(s_q.release_m);
          OFS_RADIO: begin
            s_d.rdata[RADIO_EN_BIT] = s_q.radio_en;
            s_d.rdata[RADIO_ALT_BIT] = s_q.radio_alt;
          end
          // Unmapped offsets read as zero
          default: s_d.rdata = '0;
        endcase
      end
    end
    // Data phase of a write
    if (s_q.wr_pend) begin
      case (s_q.wr_addr)
        OFS_DIR: s_d.dir = hwdata[N_GIO-1:0];
        OFS_DOUT: s_d.dout = hwdata[N_GIO+N_DO-1:0];
        OFS_PULL_EN: s_d.pull_en = hwdata[N_GIO-1:0];
        OFS_PULL_UP: s_d.pull_up = hwdata[N_GIO-1:0];
        OFS_INT_EN: s_d.int_en = hwdata[N_GIO-1:0];
        OFS_INT_RISE: s_d.int_rise = hwdata[N_GIO-1:0];
        OFS_INT_STAT: clr = hwdata[N_GIO-1:0];
        OFS_PERIPH: begin
          s_d.per_en = hwdata[PERIPH_EN_LSB +: N_PERIPH];
          s_d.per_alt = hwdata[PERIPH_ALT_LSB +: N_PERIPH];
        end
        OFS_RELEASE: s_d.release_m = hwdata[N_GIO-1:0];
        OFS_RADIO: begin
          s_d.radio_en = hwdata[RADIO_EN_BIT];
          s_d.radio_alt = hwdata[RADIO_ALT_BIT];
        end
        // Writes to read-only or unmapped offsets are dropped
        default: clr = '0;
      endcase
    end
    // A new edge in the clearing cycle survives the clear
    s_d.int_stat = (s_q.int_stat & ~clr) | set_vec;
    // Sleep entry copies the pin picture into the port registers and drops peripherals
    if (sleep_entry) begin
      s_d.dir = eff_dir;
      s_d.dout[N_GIO-1:0] = eff_out;
      s_d.per_en = '0;
      s_d.radio_en = 1'b0;
    end
    // Pin drivers, pulls are untouched by sleep so they hold through it
    s_d.pin_out = eff_out;
    s_d.pin_oe_n = ~eff_dir;
    s_d.pu = s_q.pull_en & s_q.pull_up;
    s_d.pd = s_q.pull_en & ~s_q.pull_up;
    s_d.do_q = s_q.dout[DO_LSB +: N_DO];
    s_d.irq = |(s_d.int_stat & s_q.int_en);
    s_d.wake = s_q.sleep & (|(s_d.int_stat & s_q.int_en));
  end

  // ********************************************
  // State register
  // ********************************************
  // Reset leaves every pin an undriven input with its default pull
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.pull_en <= PULL_EN_RST;
      s_q.pull_up <= PULL_UP_RST;
      s_q.pin_oe_n <= '1;
      s_q.pu <= PULL_EN_RST & PULL_UP_RST;
      s_q.pd <= PULL_EN_RST & ~PULL_UP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ********************************************
  // Outputs
  // ********************************************
  assign hreadyout = 1'b1; // No wait states
  assign hresp = 1'b0; // Always OKAY
  assign hrdata = s_q.rdata;
  assign general_io_pin_out = s_q.pin_out;
  assign general_io_pin_oe_n = s_q.pin_oe_n;
  assign pullup_resistor_en = s_q.pu;
  assign pulldown_resistor_en = s_q.pd;
  assign output_only_pin = s_q.do_q;
  assign pin_level = s_q.sync2;
  assign irq = s_q.irq;
  assign wake_event = s_q.wake;

  // ********************************************
  // Assertions
  // ********************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_enter;
    sleep_req && !s_q.sleep;
  endsequence

  sequence s_held;
    (s_q.per_en == '0) && !s_q.radio_en;
  endsequence

  a_reset_state: assert property ($rose(rstn) |-> (&general_io_pin_oe_n)
    && (s_q.per_en == '0) && (pullup_resistor_en == (PULL_EN_RST & PULL_UP_RST)))
    else $error("pins not inputs after reset");
  a_sync_delay: assert property (rstn |-> ##2 pin_level == $past(general_io_pin_in, 2))
    else $error("pin level not two cycles behind pin");
  a_edge_sets: assert property (set_vec != '0 |=>
    (s_q.int_stat & $past(set_vec)) == $past(set_vec))
    else $error("selected edge did not set status");
  a_irq_gate: assert property (##1 irq == |($past(s_d.int_stat) & $past(s_q.int_en)))
    else $error("request not gated by enable");
  // A write-one-clear in the same cycle may legally drop the request
  a_wake_sleep: assert property (s_q.sleep && (s_q.int_stat & s_q.int_en) != '0
    && !(s_q.wr_pend && (s_q.wr_addr == OFS_INT_STAT)) |=> wake_event)
    else $error("no wake from enabled pin event");
  a_sleep_hold: assert property (s_enter |=> s_held and
    (s_q.dir == $past(eff_dir)) and (s_q.dout[N_GIO-1:0] == $past(eff_out)))
    else $error("sleep entry did not hold pin picture");
  a_periph_pins: assert property (##1
    ((general_io_pin_out ^ $past(per_o)) & $past(claim & ~radio_m)) == '0)
    else $error("claimed pin not driven by peripheral");
  a_free_pins: assert property (##1
    ((~general_io_pin_oe_n ^ $past(s_q.dir)) & $past(~claim & ~radio_m)) == '0)
    else $error("free pin direction differs from register");
  a_radio_tx: assert property (s_q.radio_en && !s_q.radio_alt |=>
    general_io_pin_out[TX_PIN_A] == $past(radio_tx_state) && !general_io_pin_oe_n[TX_PIN_A])
    else $error("transmit indicator wrong");
  a_radio_rx: assert property (s_q.radio_en && s_q.radio_alt |=>
    general_io_pin_out[RX_PIN_B] == $past(radio_rx_state) && !general_io_pin_oe_n[RX_PIN_B])
    else $error("receive indicator wrong");
  a_pull_out: assert property (##2 pullup_resistor_en == $past(s_q.pull_en & s_q.pull_up)
    && output_only_pin == $past(s_q.dout[DO_LSB +: N_DO]))
    else $error("pull or output-only pin wrong");

endmodule
`default_nettype wire

// file: tb/pin_env.sv
// Far-side model: board wiring, switches and pull resistors on the port pins
`timescale 1ns/1ps
`default_nettype none
module pin_env (
  // Clock
  input wire logic sys_clk,
  // Design side of each pin
  input wire logic [gpio_port_pkg::N_GIO-1:0] pin_out,
  input wire logic [gpio_port_pkg::N_GIO-1:0] pin_oe_n,
  input wire logic [gpio_port_pkg::N_GIO-1:0] pu_en,
  input wire logic [gpio_port_pkg::N_GIO-1:0] pd_en,
  // External switches
  input wire logic [gpio_port_pkg::N_GIO-1:0] ext_val,
  input wire logic [gpio_port_pkg::N_GIO-1:0] ext_en,
  // Resolved wire level
  output logic [gpio_port_pkg::N_GIO-1:0] pin_in
);
  import gpio_port_pkg::*;
  // ********************************************
  // Wire resolution
  // ********************************************
  logic [N_GIO-1:0] last_q; // Last level, so a floating pin never holds still
  // Floating pins flip every cycle, the simulator must not pick a value for us
  always_ff @(posedge sys_clk) begin
    last_q <= pin_in;
  end
  // Port drive beats switches, switches beat pulls
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
    | (pin_oe_n & ~ext_en & pu_en)
    | (pin_oe_n & ~ext_en & ~pu_en & ~pd_en & ~last_q);
endmodule
`default_nettype wire

// file: tb/general_purpose_io_port_tb_top.sv
// Testbench: register bus stimulus, pin environment and result queue for the pin port
`timescale 1ns/1ps
`default_nettype none
module general_purpose_io_port_tb_top;
  import gpio_port_pkg::*;
  // ********************************************
  // Signals
  // ********************************************
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hready;
  logic hreadyout, hresp;
  logic [31:0] hrdata;
  logic [N_GIO-1:0] pin_in, pin_out, oe_n, pu, pd, lvl;
  logic [N_GIO-1:0] ext_val = '0;
  logic [N_GIO-1:0] ext_en = '0;
  logic [N_DO-1:0] do_pin;
  logic [N_PERIPH-1:0][N_GIO-1:0] p_out = '0;
  logic [N_PERIPH-1:0][N_GIO-1:0] p_drv = '0;
  logic radio_tx_state = 1'b0;
  logic radio_rx_state = 1'b0;
  logic sleep_req = 1'b0;
  logic wake_event, irq;
  logic rd_dp = 1'b0; // A read is in its data phase
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  int error_cnt = 0;
  int samples_checked = 0;
  assign hready = hreadyout; // Single slave drives the bus ready
  // Clock, 125 MHz
  always #4 sys_clk = ~sys_clk;
  // ********************************************
  // Design and far side
  // ********************************************
  gpio_port uut (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .general_io_pin_in(pin_in),
    .general_io_pin_out(pin_out), .general_io_pin_oe_n(oe_n), .pullup_resistor_en(pu),
    .pulldown_resistor_en(pd), .output_only_pin(do_pin), .periph_out(p_out),
    .periph_drive(p_drv), .pin_level(lvl), .radio_tx_state(radio_tx_state),
    .radio_rx_state(radio_rx_state), .sleep_req(sleep_req), .wake_event(wake_event),
    .irq(irq));
  pin_env env (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe_n(oe_n), .pu_en(pu),
    .pd_en(pd), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
  // ********************************************
  // Tasks
  // ********************************************
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic give_verdict();
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One AHB-Lite single transfer; a read leaves its expectation in the queue
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] e);
    @(posedge sys_clk);
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsel <= 1'b1;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    rd_dp <= ~w;
    if (!w) exp_q.push_back(e);
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd_dp <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, 32'h0000_0000);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0000_0000, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Read data is taken at the edge that closes the data phase
  always @(posedge sys_clk) begin
    if (rd_dp === 1'b1) begin
      chk(hrdata, exp_q.pop_front());
      chk(hresp, 32'h0000_0000);
    end
  end
  // Watchdog against a hung bus or sequence
  initial begin
    idle(20000);
    error_cnt++;
    give_verdict();
  end
  // ********************************************
  // Main sequence
  // ********************************************
  initial begin
    logic [N_GIO-1:0] dir, dout, ev, u, pe, pv;
    int tp, rp;
    void'($urandom(32'h3f4c));
    idle(5);
    rstn <= 1'b1;
    idle(1);
    // Defaults after reset
    chk(oe_n, 18'h3_FFFF);
    chk(pu, PULL_UP_RST);
    rd(OFS_DIR, 32'h0000_0000);
    rd(OFS_PULL_EN, 32'h0003_FFFF);
    rd(OFS_PERIPH, 32'h0000_0000);
    rd(8'h3C, 32'h0000_0000);
    // Random directions and levels, pulls dropped on outputs
    dir = $urandom;
    dout = $urandom;
    ev = ($urandom & 18'h3_F3FF) | 18'h0_0800;
    ext_val <= ev;
    ext_en <= '1;
    wr(OFS_PULL_EN, {14'h0, ~dir});
    wr(OFS_DIR, {14'h0, dir});
    wr(OFS_DOUT, {14'h0, dout});
    idle(5);
    rd(OFS_DIR, {14'h0, dir});
    rd(OFS_LEVEL, {14'h0, (dir & dout) | (~dir & ev)});
    chk(lvl, (dir & dout) | (~dir & ev));
    // Output-only pins
    wr(OFS_DOUT, 32'h0008_0000);
    idle(3);
    chk(do_pin, 2'b10);
    // Pull selection per pin
    u = $urandom;
    pe = $urandom;
    wr(OFS_PULL_UP, {14'h0, u});
    wr(OFS_PULL_EN, {14'h0, pe});
    idle(3);
    chk(pu, pe & u);
    chk(pd, pe & ~u);
    // Peripheral takes, releases and moves its pins
    pv = $urandom;
    p_out[0] <= pv;
    p_drv[0] <= '1;
    wr(OFS_DIR, 32'h0000_0000);
    wr(OFS_PERIPH, 32'h0000_0001);
    idle(3);
    chk(18'(~oe_n), MAP_A[0]);
    chk(pin_out & MAP_A[0], pv & MAP_A[0]);
    wr(OFS_RELEASE, 32'h0000_0001);
    idle(3);
    chk(18'(~oe_n), MAP_A[0] & 18'h3_FFFE);
    wr(OFS_RELEASE, 32'h0000_0000);
    wr(OFS_PERIPH, 32'h0000_0101);
    idle(3);
    chk(18'(~oe_n), MAP_B[0]);
    // Edge interrupts: pin 10 rising and enabled, pin 11 falling and masked
    wr(OFS_INT_RISE, 32'h0000_0400);
    wr(OFS_INT_EN, 32'h0000_0400);
    idle(5);
    wr(OFS_INT_STAT, 32'h0003_FFFF);
    rd(OFS_INT_STAT, 32'h0000_0000);
    // Sleep entry holds the effective drive
    sleep_req <= 1'b1;
    idle(3);
    rd(OFS_PERIPH, 32'h0000_0100);
    rd(OFS_DIR, {14'h0, MAP_B[0]});
    rd(OFS_DOUT, {12'h0, 2'b10, pv & MAP_B[0]});
    chk(18'(~oe_n), MAP_B[0]);
    ext_val <= (ev & 18'h3_F3FF) | 18'h0_0400;
    idle(5);
    chk(wake_event, 1'b1);
    sleep_req <= 1'b0;
    idle(3);
    chk(wake_event, 1'b0);
    chk(18'(~oe_n), MAP_B[0]);
    chk(pin_out & MAP_B[0], pv & MAP_B[0]);
    chk(irq, 1'b1);
    rd(OFS_INT_STAT, 32'h0000_0C00);
    wr(OFS_INT_STAT, 32'h0000_0400);
    rd(OFS_INT_STAT, 32'h0000_0800);
    idle(2);
    chk(irq, 1'b0);
    // Radio indicators, both pin pairs and all state combinations
    wr(OFS_DIR, 32'h0000_0000);
    for (int k = 0; k < 8; k++) begin
      radio_tx_state <= k[0];
      radio_rx_state <= k[1];
      wr(OFS_RADIO, {30'h0, k[2], 1'b1});
      idle(3);
      tp = k[2] ? TX_PIN_B : TX_PIN_A;
      rp = k[2] ? RX_PIN_B : RX_PIN_A;
      chk(pin_out[tp], k[0]);
      chk(oe_n[tp], 1'b0);
      chk(pin_out[rp], k[1]);
      chk(oe_n[rp], 1'b0);
    end
    // Unused pins parked as pulled-up inputs with nothing on the board read high
    ext_en <= '0;
    wr(OFS_RADIO, 32'h0000_0000);
    wr(OFS_PULL_UP, 32'h0003_FFFF);
    wr(OFS_PULL_EN, 32'h0003_FFFF);
    idle(5);
    rd(OFS_LEVEL, 32'h0003_FFFF);
    chk(lvl, 18'h3_FFFF);
    idle(2);
    give_verdict();
  end
endmodule
`default_nettype wire
